// *** core/tdl_dev.sv ***
`timescale 1ns/1ps
module tdl_dev
  import tdl_pkg::*;
(
  // core clock and control
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // oversampling clock of the link logic
  input wire logic LINK_CLK_I,
  // two-wire link
  tdl_if.dev LINK,
  // on_chip_debug_unit state
  output logic DEBUG_MODE_O,
  // received bytes: {first, bad, data}
  output logic [FIFO_W-1:0] RX_WORD_O,
  output logic RX_VALID_O,
  input wire logic RX_READY_I,
  // bytes for the host to read
  input wire logic [DATA_W-1:0] TX_DATA_I,
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  // command events
  output logic CMD_END_O,
  output logic TX_ERR_O
);
  ////////////////////////////////////////////////////////////////////////
  // core domain
  logic [1:0] c_scl_q;
  logic [1:0] c_sda_q;
  logic dbg_r;
  logic lock_r;
  tdl_cnt_t hold_r;
  tdl_cnt_t win_r;
  logic [1:0] c_rxt_q;
  logic [1:0] c_txr_q;
  logic [1:0] c_stp_q;
  logic [2:0] c_err_q;
  logic rx_ack_r;
  logic tx_ack_r;
  logic done_r;
  logic [DATA_W-1:0] tx_byte_r;
  logic c_rx_pend;
  logic c_fifo_rdy;
  logic [FIFO_W-1:0] rx_word_r;
  // link domain
  logic [1:0] l_scl_q;
  logic [1:0] l_sda_q;
  logic [1:0] l_ce_q;
  logic [1:0] l_dbg_q;
  logic [1:0] l_rxa_q;
  logic [1:0] l_txa_q;
  logic [1:0] l_dn_q;
  logic scl_p;
  logic sda_p;
  tdl_lmode_e mode_r;
  logic [BIT_W-1:0] bit_r;
  logic [DATA_W-1:0] sh_r;
  logic [DATA_W-1:0] dbyte_r;
  logic [LEN_W-1:0] cnt_r;
  logic good_r;
  logic first_r;
  logic loaded_r;
  logic rx_tgl_r;
  logic tx_req_r;
  logic stop_tgl_r;
  logic err_tgl_r;
  logic stretch_r;
  logic sda_oe_n_r;
  logic drive_oe_n;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      c_scl_q <= SYNC_RST;
      c_sda_q <= SYNC_RST;
    end else if (CE_I) begin
      c_scl_q <= {c_scl_q[0], LINK.debug_serial_clock};
      c_sda_q <= {c_sda_q[0], LINK.debug_serial_data};
    end
  end

  // window closes for good after power-up
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dbg_r <= 1'b0;
      lock_r <= 1'b0;
      hold_r <= '0;
      win_r <= '0;
    end else if (CE_I && !dbg_r && !lock_r) begin
      win_r <= win_r + 1'b1;
      if (!c_scl_q[1] && !c_sda_q[1]) begin
        hold_r <= hold_r + 1'b1;
      end else begin
        hold_r <= '0;
      end
      if (!c_scl_q[1] && !c_sda_q[1] && hold_r == ENTRY_HOLD_CYC - 1'b1) begin
        dbg_r <= 1'b1;
      end else if (win_r == ENTRY_WIN_CYC - 1'b1) begin
        lock_r <= 1'b1;
      end
    end
  end
  assign DEBUG_MODE_O = dbg_r;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      c_rxt_q <= '0;
      c_txr_q <= '0;
      c_stp_q <= '0;
      c_err_q <= '0;
    end else if (CE_I) begin
      c_rxt_q <= {c_rxt_q[0], rx_tgl_r};
      c_txr_q <= {c_txr_q[0], tx_req_r};
      c_stp_q <= {c_stp_q[0], stop_tgl_r};
      c_err_q <= {c_err_q[1:0], err_tgl_r};
    end
  end

  // received words wait here; full fifo stalls the handshake
  assign c_rx_pend = c_rxt_q[1] ^ rx_ack_r;
  tdl_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) tdl_fifo_i (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .in_valid_i(c_rx_pend),
    .in_data_i(rx_word_r),
    .in_ready_o(c_fifo_rdy),
    .out_valid_o(RX_VALID_O),
    .out_ready_i(RX_READY_I),
    .out_data_o(RX_WORD_O)
  );
  assign TX_READY_O = c_txr_q[1] ^ tx_ack_r;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_ack_r <= 1'b0;
      tx_ack_r <= 1'b0;
      tx_byte_r <= '0;
      done_r <= 1'b0;
      CMD_END_O <= 1'b0;
      TX_ERR_O <= 1'b0;
    end else if (CE_I) begin
      if (c_rx_pend && c_fifo_rdy) begin
        rx_ack_r <= ~rx_ack_r;
      end
      if (TX_READY_O && TX_VALID_I) begin
        tx_byte_r <= TX_DATA_I;
        tx_ack_r <= ~tx_ack_r;
      end
      // wait ends once the command is drained
      CMD_END_O <= 1'b0;
      if ((c_stp_q[1] ^ done_r) && !c_rx_pend && !RX_VALID_O) begin
        done_r <= ~done_r;
        CMD_END_O <= 1'b1;
      end
      TX_ERR_O <= c_err_q[2] ^ c_err_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain; clock enable arrives through its own synchroniser
  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      l_scl_q <= SYNC_RST;
      l_sda_q <= SYNC_RST;
      l_ce_q <= '0;
      l_dbg_q <= '0;
      l_rxa_q <= '0;
      l_txa_q <= '0;
      l_dn_q <= '0;
    end else begin
      l_scl_q <= {l_scl_q[0], LINK.debug_serial_clock};
      l_sda_q <= {l_sda_q[0], LINK.debug_serial_data};
      l_ce_q <= {l_ce_q[0], CE_I};
      l_dbg_q <= {l_dbg_q[0], dbg_r};
      l_rxa_q <= {l_rxa_q[0], rx_ack_r};
      l_txa_q <= {l_txa_q[0], tx_ack_r};
      l_dn_q <= {l_dn_q[0], done_r};
    end
  end

  logic l_scl;
  logic l_sda;
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;
  logic tx_have;
  logic stop_w;
  logic need_wait;
  assign l_scl = l_scl_q[1];
  assign l_sda = l_sda_q[1];
  assign rise_ev = l_scl && !scl_p;
  assign fall_ev = !l_scl && scl_p;
  // data falls while clock stays high
  assign start_ev = l_scl && scl_p && sda_p && !l_sda;
  // data rises while clock stays high
  assign stop_ev = l_scl && scl_p && !sda_p && l_sda;
  assign tx_have = !(tx_req_r ^ l_txa_q[1]);
  assign stop_w = stop_tgl_r ^ l_dn_q[1];
  // hold clock while a byte cannot move
  assign need_wait = stop_w || (bit_r == '0 && mode_r != LM_IDLE &&
    ((rx_tgl_r ^ l_rxa_q[1]) || (mode_r == LM_TX && !loaded_r)));

  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else if (l_ce_q[1]) begin
      scl_p <= l_scl;
      sda_p <= l_sda;
    end
  end

  // packets only count inside start/stop framing
  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_r <= LM_IDLE;
      bit_r <= '0;
      sh_r <= '0;
      good_r <= 1'b0;
      first_r <= 1'b0;
      cnt_r <= '0;
      rx_tgl_r <= 1'b0;
      rx_word_r <= '0;
      tx_req_r <= 1'b0;
      loaded_r <= 1'b0;
      dbyte_r <= '0;
      stop_tgl_r <= 1'b0;
      err_tgl_r <= 1'b0;
    end else if (l_ce_q[1] && l_dbg_q[1]) begin
      if (start_ev) begin
        mode_r <= LM_RX;
        bit_r <= '0;
        first_r <= 1'b1;
      end else if (stop_ev) begin
        if (mode_r != LM_IDLE) begin
          stop_tgl_r <= ~stop_tgl_r;
        end
        mode_r <= LM_IDLE;
      end else if (rise_ev && mode_r != LM_IDLE) begin
        bit_r <= (bit_r == ACK_BIT) ? '0 : bit_r + 1'b1;
        case (mode_r)
          LM_RX: begin
            if (bit_r < PAR_BIT) begin
              sh_r <= {sh_r[DATA_W-2:0], l_sda};
            end else if (bit_r == PAR_BIT) begin
              good_r <= !(tdl_par(sh_r) ^ l_sda);
              rx_word_r <= {first_r, tdl_par(sh_r) ^ l_sda, sh_r};
              rx_tgl_r <= ~rx_tgl_r;
            end else begin
              first_r <= 1'b0;
              // read command turns the data line round
              if (first_r && good_r && sh_r[RD_FLAG]) begin
                cnt_r <= sh_r[LEN_W-1:0];
                if (sh_r[LEN_W-1:0] == '0) begin
                  mode_r <= LM_SKIP;
                end else begin
                  mode_r <= LM_TX;
                  tx_req_r <= ~tx_req_r;
                  loaded_r <= 1'b0;
                end
              end
            end
          end
          LM_TX: begin
            if (bit_r == ACK_BIT) begin
              loaded_r <= 1'b0;
              cnt_r <= cnt_r - 1'b1;
              if (l_sda) begin
                mode_r <= LM_SKIP;
                err_tgl_r <= ~err_tgl_r;
              end else if (cnt_r == LEN_W'(1)) begin
                mode_r <= LM_SKIP;
              end else begin
                tx_req_r <= ~tx_req_r;
              end
            end
          end
          default: begin
          end
        endcase
      end
      if (mode_r == LM_TX && bit_r == '0 && !loaded_r && tx_have) begin
        dbyte_r <= tx_byte_r;
        loaded_r <= 1'b1;
      end
    end
  end

  always_comb begin
    drive_oe_n = 1'b1;
    case (mode_r)
      LM_RX: begin
        // ack low when good, released when bad
        if (bit_r == ACK_BIT) begin
          drive_oe_n = !good_r;
        end
      end
      LM_TX: begin
        if (loaded_r && bit_r != ACK_BIT) begin
          drive_oe_n = tdl_bit(dbyte_r, bit_r);
        end
      end
      default: drive_oe_n = 1'b1;
    endcase
  end

  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stretch_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (l_ce_q[1]) begin
      // hold clock low while waiting or data settles
      stretch_r <= l_dbg_q[1] && ((need_wait &&
        (fall_ev || stretch_r || stop_w)) ||
        (stretch_r && drive_oe_n != sda_oe_n_r));
      // data moves only while clock low
      if (!l_scl) begin
        sda_oe_n_r <= drive_oe_n;
      end
    end
  end

  // open drain; clock is only ever held low
  assign LINK.d_scl_o = 1'b0;
  assign LINK.d_scl_oe_n = !stretch_r;
  assign LINK.d_sda_o = 1'b0;
  assign LINK.d_sda_oe_n = sda_oe_n_r;
endmodule

// *** core/tdl_fifo.sv ***
`timescale 1ns/1ps
module tdl_fifo
  import tdl_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_D
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;

  assign in_ready_o = !((wr_r[AW] != rd_r[AW]) &&
                        (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid_o = (wr_r != rd_r);
  assign out_data_o = mem[rd_r[AW-1:0]];
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

// *** core/tdl_host.sv ***
`timescale 1ns/1ps
module tdl_host
  import tdl_pkg::*;
#(
  parameter int DEPTH = CMD_D
) (
  // clock and control
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic BOOT_I,
  // two-wire link
  tdl_if.host LINK,
  // command bytes
  input wire logic CMD_VALID_I,
  input wire logic [DATA_W-1:0] CMD_DATA_I,
  input wire logic CMD_LAST_I,
  output logic CMD_READY_O,
  // read bytes and status
  output logic [DATA_W-1:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic BUSY_O,
  output logic ERR_O,
  output logic LINK_UP_O
);
  localparam int IW = $clog2(DEPTH);
  logic [DATA_W-1:0] mem [DEPTH];
  tdl_hst_e st_r;
  tdl_cnt_t tm_r;
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic [BIT_W-1:0] bit_r;
  logic [IW-1:0] idx_r;
  logic [IW-1:0] last_r;
  logic [LEN_W-1:0] rcnt_r;
  logic [DATA_W-1:0] rsh_r;
  logic rd_r;
  logic ack_r;
  logic good_r;
  logic retry_r;
  logic scl_oe_n_r;
  logic sda_oe_n_r;
  logic pwr_r;
  logic half;
  logic rd_cmd;
  logic lo_val;

  assign half = (tm_r == HALF_CYC - 1'b1);
  assign rd_cmd = mem[0][RD_FLAG];
  assign CMD_READY_O = (st_r == HS_IDLE);
  assign BUSY_O = (st_r != HS_IDLE);
  assign lo_val = rd_r ? ((bit_r == ACK_BIT) ? !good_r : 1'b1)
                       : ((bit_r == ACK_BIT) ? 1'b1
                                             : tdl_bit(mem[idx_r], bit_r));

  always_ff @(posedge CLK_I) begin
    if (CE_I && CMD_READY_O && CMD_VALID_I) begin
      mem[idx_r] <= CMD_DATA_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_q <= SYNC_RST;
      sda_q <= SYNC_RST;
    end else if (CE_I) begin
      scl_q <= {scl_q[0], LINK.debug_serial_clock};
      sda_q <= {sda_q[0], LINK.debug_serial_data};
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r <= HS_OFF;
      tm_r <= '0;
      bit_r <= '0;
      idx_r <= '0;
      last_r <= '0;
      rcnt_r <= '0;
      rsh_r <= '0;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      good_r <= 1'b0;
      retry_r <= 1'b0;
      scl_oe_n_r <= 1'b0;
      sda_oe_n_r <= 1'b0;
      pwr_r <= 1'b0;
      RD_DATA_O <= '0;
      RD_VALID_O <= 1'b0;
      ERR_O <= 1'b0;
      LINK_UP_O <= 1'b0;
    end else if (CE_I) begin
      tm_r <= tm_r + 1'b1;
      RD_VALID_O <= 1'b0;
      ERR_O <= 1'b0;
      case (st_r)
        // lines low across power-up of the target
        HS_OFF: begin
          pwr_r <= 1'b0;
          scl_oe_n_r <= 1'b0;
          sda_oe_n_r <= 1'b0;
          LINK_UP_O <= 1'b0;
          if (tm_r == PWR_OFF_CYC - 1'b1) begin
            st_r <= HS_PWR;
            tm_r <= '0;
          end
        end
        HS_PWR: begin
          pwr_r <= 1'b1;
          if (tm_r == ENTRY_DRV_CYC - 1'b1) begin
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            LINK_UP_O <= 1'b1;
            st_r <= HS_GAP;
            tm_r <= '0;
          end
        end
        HS_IDLE: begin
          tm_r <= '0;
          if (BOOT_I) begin
            st_r <= HS_OFF;
          end else if (CMD_VALID_I) begin
            if (CMD_LAST_I || idx_r == IW'(DEPTH - 1)) begin
              last_r <= idx_r;
              idx_r <= '0;
              st_r <= HS_ST1;
            end else begin
              idx_r <= idx_r + 1'b1;
            end
          end
        end
        HS_ST1: begin
          if (!scl_q[1] || !sda_q[1]) begin
            tm_r <= '0;
          end else if (half) begin
            sda_oe_n_r <= 1'b0;
            st_r <= HS_ST2;
            tm_r <= '0;
          end
        end
        HS_ST2: begin
          if (half) begin
            scl_oe_n_r <= 1'b0;
            bit_r <= '0;
            rd_r <= 1'b0;
            st_r <= HS_LO;
            tm_r <= '0;
          end
        end
        // data set only while clock low
        HS_LO: begin
          sda_oe_n_r <= lo_val;
          if (half) begin
            scl_oe_n_r <= 1'b1;
            st_r <= HS_HI;
            tm_r <= '0;
          end
        end
        HS_HI: begin
          // wait until the clock really rises
          if (!scl_q[1]) begin
            tm_r <= '0;
          end else if (tm_r == '0) begin
            if (bit_r < PAR_BIT) begin
              rsh_r <= {rsh_r[DATA_W-2:0], sda_q[1]};
            end else if (bit_r == PAR_BIT) begin
              good_r <= !(tdl_par(rsh_r) ^ sda_q[1]);
            end else begin
              ack_r <= sda_q[1];
            end
          end else if (half) begin
            tm_r <= '0;
            scl_oe_n_r <= 1'b0;
            st_r <= HS_LO;
            bit_r <= bit_r + 1'b1;
            if (bit_r == ACK_BIT) begin
              bit_r <= '0;
              if (rd_r ? !good_r : ack_r) begin
                retry_r <= 1'b1;
                ERR_O <= 1'b1;
                st_r <= HS_SP1;
              end else if (rd_r) begin
                RD_DATA_O <= rsh_r;
                RD_VALID_O <= 1'b1;
                rcnt_r <= rcnt_r - 1'b1;
                if (rcnt_r == LEN_W'(1)) begin
                  st_r <= HS_SP1;
                end
              end else if (rd_cmd) begin
                rd_r <= 1'b1;
                rcnt_r <= mem[0][LEN_W-1:0];
                if (mem[0][LEN_W-1:0] == '0) begin
                  st_r <= HS_SP1;
                end
              end else if (idx_r == last_r) begin
                st_r <= HS_SP1;
              end else begin
                idx_r <= idx_r + 1'b1;
              end
            end
          end
        end
        HS_SP1: begin
          sda_oe_n_r <= 1'b0;
          if (half) begin
            scl_oe_n_r <= 1'b1;
            st_r <= HS_SP2;
            tm_r <= '0;
          end
        end
        HS_SP2: begin
          if (!scl_q[1]) begin
            tm_r <= '0;
          end else if (half) begin
            sda_oe_n_r <= 1'b1;
            st_r <= HS_SP3;
            tm_r <= '0;
          end
        end
        HS_SP3: begin
          if (half) begin
            st_r <= HS_GAP;
            tm_r <= '0;
          end
        end
        HS_GAP: begin
          // target may hold the clock low while it works
          if (!scl_q[1]) begin
            tm_r <= '0;
          end else if (half) begin
            tm_r <= '0;
            idx_r <= '0;
            retry_r <= 1'b0;
            st_r <= retry_r ? HS_ST1 : HS_IDLE;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  assign LINK.h_scl_o = 1'b0;
  assign LINK.h_scl_oe_n = scl_oe_n_r;
  assign LINK.h_sda_o = 1'b0;
  assign LINK.h_sda_oe_n = sda_oe_n_r;
  assign LINK.pwr_en = pwr_r;
endmodule

// *** core/tdl_if.sv ***
`timescale 1ns/1ps
interface tdl_if;
  logic pwr_en;
  logic h_scl_o;
  logic h_scl_oe_n;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_scl_o;
  logic d_scl_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic debug_serial_clock;
  logic debug_serial_data;
  // wired-AND of two open-drain ends with pull-ups
  assign debug_serial_clock = (h_scl_oe_n | h_scl_o) & (d_scl_oe_n | d_scl_o);
  assign debug_serial_data = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
  modport dev (
    input debug_serial_clock, debug_serial_data,
    output d_scl_o, d_scl_oe_n, d_sda_o, d_sda_oe_n
  );
  modport host (
    input debug_serial_clock, debug_serial_data,
    output h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n, pwr_en
  );
endinterface

// *** core/tdl_pkg.sv ***
// Function
// - debug entry only by power-up pin pattern
// - no debug entry after power-up window
// - packet is 8 data, parity, acknowledge
// - parity makes ones count even
// - receiver acknowledges low good, high bad
// - transmitter samples acknowledge, handles error
// - host stops and resends failed command
// - command framed by start and stop
// - start: data falls while clock high
// - stop: data rises while clock high
// - device holds bus waiting after stop
// - data changes only while clock low
// - device stretches clock, host waits high
// - both lines open-drain wired-AND
// - device: clock input, held low to stretch; data both ways
package tdl_pkg;
  localparam int CLK_MHZ = 25;
  localparam int CNT_W = 12;
  localparam int DATA_W = 8;
  localparam int BIT_W = 4;
  localparam logic [BIT_W-1:0] PAR_BIT = 4'h8;
  localparam logic [BIT_W-1:0] ACK_BIT = 4'h9;
  localparam int RD_FLAG = 7;
  localparam int LEN_W = 7;
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 16;
  localparam int CMD_D = 16;
  localparam int ENTRY_HOLD_NS = 2000;
  localparam int ENTRY_WIN_NS = 20000;
  localparam int ENTRY_DRV_NS = 4000;
  localparam int PWR_OFF_NS = 10000;
  localparam int HALF_NS = 200;
  typedef logic [CNT_W-1:0] tdl_cnt_t;
  // least times round up, the window rounds down
  localparam tdl_cnt_t ENTRY_HOLD_CYC =
    CNT_W'((ENTRY_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam tdl_cnt_t ENTRY_WIN_CYC = CNT_W'(ENTRY_WIN_NS * CLK_MHZ / 1000);
  localparam tdl_cnt_t ENTRY_DRV_CYC =
    CNT_W'((ENTRY_DRV_NS * CLK_MHZ + 999) / 1000);
  localparam tdl_cnt_t PWR_OFF_CYC =
    CNT_W'((PWR_OFF_NS * CLK_MHZ + 999) / 1000);
  localparam tdl_cnt_t HALF_CYC = CNT_W'((HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [1:0] SYNC_RST = 2'h3;

  typedef enum logic [1:0] {LM_IDLE, LM_RX, LM_TX, LM_SKIP} tdl_lmode_e;
  typedef enum logic [3:0] {
    HS_OFF, HS_PWR, HS_IDLE, HS_ST1, HS_ST2, HS_LO, HS_HI,
    HS_SP1, HS_SP2, HS_SP3, HS_GAP
  } tdl_hst_e;

  function automatic logic tdl_par(input logic [DATA_W-1:0] b);
    return ^b;
  endfunction

  // line level of packet bit i, msb first, parity at bit 8
  function automatic logic tdl_bit(input logic [DATA_W-1:0] b,
                                   input logic [BIT_W-1:0] i);
    logic [2:0] k;
    k = 3'(4'h7 - i);
    if (i < PAR_BIT) begin
      return b[k];
    end
    return tdl_par(b);
  endfunction
endpackage

// *** verif/tdl_chk.sv ***
`timescale 1ns/1ps
module tdl_chk (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic LINK_CLK_I,
  // link signals
  input wire logic pwr_en,
  input wire logic h_scl_o,
  input wire logic h_sda_o,
  input wire logic h_scl_oe_n,
  input wire logic h_sda_oe_n,
  input wire logic d_scl_o,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic debug_serial_clock,
  input wire logic debug_serial_data
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////
  a_host_od: assert property (!h_scl_o && !h_sda_o)
    else $error("host drives a line high");
  a_dev_od: assert property (!d_scl_o && !d_sda_o)
    else $error("device drives a line high");
  a_pwr_entry: assert property ($rose(pwr_en) |->
    (!debug_serial_clock && !debug_serial_data) [*8])
    else $error("entry pattern missing");
  a_wait_high: assert property ((h_scl_oe_n && !debug_serial_clock)
    |=> h_scl_oe_n && $stable(h_sda_oe_n))
    else $error("host moved during clock hold");
  a_dev_data: assert property (@(posedge LINK_CLK_I)
    (pwr_en && $changed(d_sda_oe_n)) |-> !debug_serial_clock)
    else $error("device data moved with clock high");
  a_start_clk: assert property (
    ($fell(debug_serial_data) && debug_serial_clock)
    |-> ##[1:8] !debug_serial_clock)
    else $error("no clock after start");
  a_stop_gap: assert property (
    ($rose(debug_serial_data) && debug_serial_clock) |=> h_scl_oe_n [*3])
    else $error("host clocked right after stop");
  a_clk_high: assert property ($rose(debug_serial_clock)
    |-> debug_serial_clock [*5])
    else $error("clock high phase too short");
endmodule

// *** verif/two_wire_debug_link_tb.sv ***
`timescale 1ns/1ps
module two_wire_debug_link_tb;
  logic clk = 0, lk = 0, rst = 1, boot = 0, cv = 0, cl = 0;
  logic rx_rdy = 0, tv = 0, stall = 0;
  logic [7:0] cd = 0, td = 0, rd_d;
  logic [9:0] rx_w;
  logic cmd_rdy, busy, err, up, rd_v, dbg, rx_v, tx_rdy, txerr, cend;
  logic [7:0] cmd_q[$], rd_q[$];
  logic [9:0] rx_q[$];
  int n_fail = 0, n_checks = 0, n, n_end = 0;
  initial forever #20 clk = ~clk;
  initial begin
    #1.7;
    forever #3 lk = ~lk;
  end
  tdl_if tdl_if_i ();
  tdl_host tdl_host_i (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .BOOT_I(boot), .LINK(tdl_if_i), .CMD_VALID_I(cv), .CMD_DATA_I(cd),
    .CMD_LAST_I(cl), .CMD_READY_O(cmd_rdy), .RD_DATA_O(rd_d),
    .RD_VALID_O(rd_v), .BUSY_O(busy), .ERR_O(err), .LINK_UP_O(up));
  tdl_dev tdl_dev_i (.CLK_I(clk), .RST_I(rst | !tdl_if_i.pwr_en),
    .CE_I(1'b1), .LINK_CLK_I(lk), .LINK(tdl_if_i), .DEBUG_MODE_O(dbg),
    .RX_WORD_O(rx_w), .RX_VALID_O(rx_v), .RX_READY_I(rx_rdy),
    .TX_DATA_I(td), .TX_VALID_I(tv), .TX_READY_O(tx_rdy),
    .CMD_END_O(cend), .TX_ERR_O(txerr));
  tdl_chk tdl_chk_i (.CLK_I(clk), .RST_I(rst), .LINK_CLK_I(lk),
    .pwr_en(tdl_if_i.pwr_en), .h_scl_o(tdl_if_i.h_scl_o),
    .h_sda_o(tdl_if_i.h_sda_o), .h_scl_oe_n(tdl_if_i.h_scl_oe_n),
    .h_sda_oe_n(tdl_if_i.h_sda_oe_n), .d_scl_o(tdl_if_i.d_scl_o),
    .d_sda_o(tdl_if_i.d_sda_o), .d_sda_oe_n(tdl_if_i.d_sda_oe_n),
    .debug_serial_clock(tdl_if_i.debug_serial_clock),
    .debug_serial_data(tdl_if_i.debug_serial_data));
  ////////////////////////////////////////
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tmo;
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask
  // hold request until ready seen, taken at next rise
  task automatic hs(input bit tx);
    int w;
    w = 0;
    while (!(tx ? tx_rdy : cmd_rdy) && w < 9000) begin
      @(negedge clk);
      w++;
    end
    if (w >= 9000) tmo();
    @(posedge clk);
  endtask
  task automatic wait_idle;
    int w;
    w = 0;
    while (!(up && cmd_rdy && !busy) && w < 20000) begin
      @(negedge clk);
      w++;
    end
    if (w >= 20000) tmo();
  endtask
  task automatic send_cmd;
    foreach (cmd_q[k]) begin
      @(negedge clk);
      cv = 1;
      cd = cmd_q[k];
      cl = (k == cmd_q.size() - 1);
      hs(0);
    end
    @(negedge clk);
    cv = 0;
  endtask
  task automatic feed(input int cnt);
    repeat (cnt) begin
      @(negedge clk);
      tv = 1;
      td = 8'($urandom);
      rd_q.push_back(td);
      hs(1);
    end
    @(negedge clk);
    tv = 0;
  endtask
  ////////////////////////////////////////
  // result watcher, pops one word every other cycle
  always @(negedge clk) begin
    if (rx_v && !rx_rdy && !stall) begin
      chk(rx_w, rx_q.size() ? rx_q.pop_front() : 10'hXXX);
      rx_rdy = 1;
    end else
      rx_rdy = 0;
    if (rd_v)
      chk({2'h0, rd_d}, {2'h0, rd_q.size() ? rd_q.pop_front() : 8'hXX});
    if (cend)
      n_end++;
    if (!rst)
      chk({8'h0, err, txerr}, 10'h0);
  end
  initial begin
    void'($urandom(40));
    repeat (8) @(negedge clk);
    rst = 0;
    wait_idle();
    chk({9'h0, dbg}, 10'h1);
    // writes, reads of 3 and 0 bytes, then a full buffer
    for (int t = 0; t < 6; t++) begin
      cmd_q.delete();
      n = (t == 5) ? 16 : 1 + $urandom % 4;
      for (int k = 0; k < n; k++)
        cmd_q.push_back(8'($urandom) & (k ? 8'hFF : 8'h7F));
      if (t == 3 || t == 4)
        cmd_q = {8'h80 | 8'(t == 3 ? 3 : 0)};
      foreach (cmd_q[k])
        rx_q.push_back({k == 0, 1'b0, cmd_q[k]});
      stall = (t == 5);
      fork
        send_cmd();
        feed(t == 3 ? 3 : 0);
      join
      if (stall) begin
        repeat (3000) @(negedge clk);
        chk({8'h0, rx_v, busy}, 10'h3);
        stall = 0;
      end
      repeat (2) @(negedge clk);
      wait_idle();
      chk(10'(rx_q.size() + rd_q.size()), 10'h0);
      chk(10'(n_end), 10'(t + 1));
      $display("test %0d done", t);
    end
    boot = 1;
    @(negedge clk);
    boot = 0;
    repeat (10) @(negedge clk);
    wait_idle();
    chk({9'h0, dbg}, 10'h1);
    $display("test power cycle done");
    give_verdict();
  end
endmodule
